/* File: src/aldm_pkg.sv */
// Shared constants and carrier types for the ADC level detect and monitor block
package aldm_pkg;
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned SAMP_W      = 14;
  localparam int unsigned MAG_W       = 13;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned ADDR_W      = 15;
  localparam int unsigned FRAME_W     = 25;
  localparam int unsigned SUBFR_W     = 5;
  localparam int unsigned SPI_INSTR_W = 16;
  localparam int unsigned SPI_TOTAL_W = 24;

  // Register offsets
  localparam logic [14:0] ADDR_DETECT_FLAGS_POWER = 15'h0040;
  localparam logic [14:0] ADDR_UPPER_THRESHOLD_LO = 15'h0247;
  localparam logic [14:0] ADDR_UPPER_THRESHOLD_HI = 15'h0248;
  localparam logic [14:0] ADDR_LOWER_THRESHOLD_LO = 15'h0249;
  localparam logic [14:0] ADDR_LOWER_THRESHOLD_HI = 15'h024A;
  localparam logic [14:0] ADDR_DWELL_TIME_LO      = 15'h024B;
  localparam logic [14:0] ADDR_DWELL_TIME_HI      = 15'h024C;
  localparam logic [14:0] ADDR_MONITOR_CONTROL    = 15'h0270;
  localparam logic [14:0] ADDR_MONITOR_PERIOD_0   = 15'h0271;
  localparam logic [14:0] ADDR_MONITOR_PERIOD_1   = 15'h0272;
  localparam logic [14:0] ADDR_MONITOR_PERIOD_2   = 15'h0273;
  localparam logic [14:0] ADDR_PEAK_HOLD_LO       = 15'h0274;
  localparam logic [14:0] ADDR_PEAK_HOLD_HI       = 15'h0275;
  localparam logic [14:0] ADDR_SERIAL_MON_EN_A    = 15'h0279;
  localparam logic [14:0] ADDR_SERIAL_MON_EN_B    = 15'h027A;

  // Field positions
  localparam int unsigned POS_PEAK_EN     = 1;
  localparam int unsigned POS_SER_EN_B    = 1;
  localparam int unsigned POS_CS_LSB      = 4;
  localparam int unsigned POS_PWR_LSB     = 6;
  localparam int unsigned POS_SPI_RD      = 23;

  // Reset values
  localparam logic [7:0] RST_REG          = 8'h00;
  localparam logic [7:0] RST_UPPER_LO     = 8'hFF;
  localparam logic [7:0] RST_UPPER_HI     = 8'h1F;
  localparam logic [7:0] RST_DWELL_LO     = 8'h01;

  // Subframe start bit and serial pad
  localparam logic       SUBFR_START      = 1'b1;
  localparam logic [6:0] FRAME_PAD        = 7'h00;

  typedef struct packed {
    logic [NUM_CH-1:0][SAMP_W-1:0] data;
  } aldm_samp_t;

  typedef struct packed {
    logic              sclk;
    logic              csb;
    logic              sdi;
  } aldm_spi_in_t;
endpackage

/* File: src/aldm_core.sv */
// ADC fast-detect, peak monitor, serial monitor embedding and SPI register port
// Functional notes
// - Flag sets when magnitude exceeds upper threshold
// - Flag clears after below-lower exceeds dwell time
// - Upper crossing reaches pin within thirty cycles
// - 13-bit lower threshold, full scale 2^13
// - Dwell time programmable 1 to 65535 cycles
// - Upper threshold held at upper_threshold_lo/upper_threshold_hi
// - Lower threshold held at lower_threshold_lo/lower_threshold_hi
// - Dwell time held at dwell_time_lo/dwell_time_hi
// - Flags readable in bits[3:0] of detect_flags_power
// - Peak detector keeps largest 13-bit magnitude
// - Observation period is 24-bit sample count
// - Bit 1 of monitor_control enables peaks
// - Enable loads period; timer counts decimated clock
// - Seed store, then keep the greater magnitude
// - At one: hold peak, reload, reseed
// - Serial enable needs serial_monitor_enable_a[1:0] and serial_monitor_enable_b[1]
// - Up to three control lanes; the frame bit rides the top one, MSB first
// - 25-bit frame, five subframes with start bits
`timescale 1ns/1ns
module aldm_core (
  input  wire logic                                clk_i,
  input  wire logic                                rst_b_i,
  input  wire logic                                spi_sclk_i,
  input  wire logic                                spi_csb_i,
  input  wire logic                                sdio_i,
  output logic                                     sdio_o,
  output logic                                     sdio_oe_o,
  input  wire aldm_pkg::aldm_samp_t                samp_i,
  input  wire logic                                samp_valid_i,
  output logic                                     samp_ready_o,
  input  wire logic                                dec_en_i,
  output logic [aldm_pkg::WORD_W-1:0]              out_data_o,
  output logic                                     out_valid_o,
  input  wire logic                                out_ready_i,
  output logic                                     fast_detect_out_a,
  output logic                                     fast_detect_out_b,
  output logic                                     fast_detect_out_c,
  output logic                                     fast_detect_out_d,
  output logic [1:0]                               power_mode_o
);

  typedef struct packed {
    logic [7:0]                                    up_lo;
    logic [7:0]                                    up_hi;
    logic [7:0]                                    lo_lo;
    logic [7:0]                                    lo_hi;
    logic [7:0]                                    dw_lo;
    logic [7:0]                                    dw_hi;
    logic [1:0]                                    pwr;
    logic [7:0]                                    mon_ctl;
    logic [2:0][7:0]                               period;
    logic [7:0]                                    ser_a;
    logic [7:0]                                    ser_b;
    logic [aldm_pkg::NUM_CH-1:0]                   fd_flag;
    logic [aldm_pkg::NUM_CH-1:0][15:0]             dwell_cnt;
    logic                                          pk_en_d1;
    logic [23:0]                                   timer;
    logic [aldm_pkg::MAG_W-1:0]                    store;
    logic                                          seed;
    logic [aldm_pkg::MAG_W-1:0]                    hold;
    logic [aldm_pkg::FRAME_W-1:0]                  frame;
    logic [4:0]                                    frame_left;
    logic                                          pend;
    logic [aldm_pkg::MAG_W-1:0]                    pend_val;
    logic                                          sclk_s1;
    logic                                          sclk_s2;
    logic                                          sclk_s3;
    logic                                          csb_s1;
    logic                                          csb_s2;
    logic                                          sdi_s1;
    logic                                          sdi_s2;
    logic [aldm_pkg::SPI_TOTAL_W-1:0]              shift;
    logic [4:0]                                    bit_cnt;
    logic [7:0]                                    rdata;
    logic                                          sdo;
    logic                                          sdo_oe;
    logic [aldm_pkg::WORD_W-1:0]                   head;
    logic [aldm_pkg::WORD_W-1:0]                   tail;
    logic                                          v0;
    logic                                          v1;
  } aldm_state_t;

  aldm_state_t st_q;
  aldm_state_t st_d;

  function automatic logic [aldm_pkg::MAG_W-1:0] aldm_abs(input logic [aldm_pkg::SAMP_W-1:0] s);
    logic [aldm_pkg::SAMP_W-1:0] n;
    n = ~s + 14'h0001;
    if (!s[aldm_pkg::SAMP_W-1])
      aldm_abs = s[aldm_pkg::MAG_W-1:0];
    else if (n[aldm_pkg::SAMP_W-1])
      aldm_abs = 13'h1FFF;
    else
      aldm_abs = n[aldm_pkg::MAG_W-1:0];
  endfunction

  logic [aldm_pkg::NUM_CH-1:0][aldm_pkg::MAG_W-1:0] mag;
  logic [aldm_pkg::MAG_W-1:0]                       up_thr;
  logic [aldm_pkg::MAG_W-1:0]                       lo_thr;
  logic [15:0]                                      dwell;

  assign up_thr = {st_q.up_hi[4:0], st_q.up_lo};
  assign lo_thr = {st_q.lo_hi[4:0], st_q.lo_lo};
  // A dwell of zero would clear on the first below-lower cycle; treat it as one
  assign dwell  = ({st_q.dw_hi, st_q.dw_lo} == 16'h0000) ? 16'h0001
                : {st_q.dw_hi, st_q.dw_lo};

  genvar gi;
  generate
    for (gi = 0; gi < aldm_pkg::NUM_CH; gi++)
    begin : g_mag
      assign mag[gi] = aldm_abs(samp_i.data[gi]);
    end
  endgenerate

  always_comb
  begin
    logic                          push;
    logic                          pop;
    logic                          rd_en;
    logic                          ser_on;
    logic [1:0]                    cs;
    logic [aldm_pkg::MAG_W-1:0]    cur;
    logic [23:0]                   per;
    logic [aldm_pkg::WORD_W-1:0]   word;
    logic [14:0]                   addr;
    logic [7:0]                    wdat;
    logic                          ctl_bit;
    push    = 1'b0;
    pop     = 1'b0;
    rd_en   = 1'b0;
    ser_on  = 1'b0;
    cs      = 2'b00;
    cur     = 13'h0000;
    per     = 24'h000000;
    word    = 16'h0000;
    addr    = 15'h0000;
    wdat    = 8'h00;
    ctl_bit = 1'b0;
    st_d    = st_q;

    // Fast detect, one cycle from sample to pin
    for (int c = 0; c < aldm_pkg::NUM_CH; c++)
    begin
      if (mag[c] > up_thr)
      begin
        st_d.fd_flag[c]   = 1'b1;
        st_d.dwell_cnt[c] = 16'h0000;
      end
      else if (mag[c] >= lo_thr)
        st_d.dwell_cnt[c] = 16'h0000;
      else if (st_q.fd_flag[c])
      begin
        if (st_q.dwell_cnt[c] >= dwell)
        begin
          st_d.fd_flag[c]   = 1'b0;
          st_d.dwell_cnt[c] = 16'h0000;
        end
        else
          st_d.dwell_cnt[c] = st_q.dwell_cnt[c] + 16'h0001;
      end
    end

    // Peak monitor on channel A at the decimated rate
    per = {st_q.period[2], st_q.period[1], st_q.period[0]};
    if (per == 24'h000000)
      per = 24'h000001;
    st_d.pk_en_d1 = st_q.mon_ctl[aldm_pkg::POS_PEAK_EN];
    cur = mag[0];
    if (!st_q.mon_ctl[aldm_pkg::POS_PEAK_EN])
    begin
      st_d.seed = 1'b1;
    end
    else if (!st_q.pk_en_d1)
    begin
      st_d.timer = per;
      st_d.seed  = 1'b1;
    end
    else if (dec_en_i)
    begin
      if (!st_q.seed && st_q.store > cur)
        cur = st_q.store;
      if (st_q.timer <= 24'h000001)
      begin
        st_d.hold  = cur;
        st_d.timer = per;
        st_d.seed  = 1'b1;
        st_d.pend     = 1'b1;
        st_d.pend_val = cur;
      end
      else
      begin
        st_d.store = cur;
        st_d.seed  = 1'b0;
        st_d.timer = st_q.timer - 24'h000001;
      end
    end

    // Serial monitor: one bit per accepted sample
    ser_on = (st_q.ser_a[1:0] == 2'b11) && st_q.ser_b[aldm_pkg::POS_SER_EN_B];
    cs     = st_q.ser_b[aldm_pkg::POS_CS_LSB +: 2];
    push   = samp_valid_i && !st_q.v1;
    pop    = out_ready_i && st_q.v0;
    if (st_q.frame_left != 5'd0)
      ctl_bit = st_q.frame[aldm_pkg::FRAME_W-1];
    if (!ser_on || cs == 2'b00)
      ctl_bit = 1'b0;
    // Upper sample bits stay; control bits take the low lanes from MSB down
    word = {samp_i.data[0][aldm_pkg::SAMP_W-1 -: 13], 3'b000};
    if (cs == 2'b00)
      word[2:0] = samp_i.data[0][0 +: 3];
    else
      word[2] = ctl_bit;
    if (cs == 2'b01)
      word[1:0] = samp_i.data[0][0 +: 2];
    else if (cs == 2'b10)
      word[0] = samp_i.data[0][0];

    if (push && st_q.frame_left != 5'd0)
    begin
      st_d.frame      = {st_q.frame[aldm_pkg::FRAME_W-2:0], 1'b0};
      st_d.frame_left = st_q.frame_left - 5'd1;
    end
    else if (push && st_d.pend && ser_on)
    begin
      // New peaks that arrive mid-frame wait; only the latest is kept
      st_d.frame = {aldm_pkg::SUBFR_START, aldm_pkg::FRAME_PAD[6:3],
                    aldm_pkg::SUBFR_START, aldm_pkg::FRAME_PAD[2:0], st_d.pend_val[12],
                    aldm_pkg::SUBFR_START, st_d.pend_val[11:8],
                    aldm_pkg::SUBFR_START, st_d.pend_val[7:4],
                    aldm_pkg::SUBFR_START, st_d.pend_val[3:0]};
      st_d.frame_left = 5'd25;
      st_d.pend       = 1'b0;
    end

    // Two-entry output buffer so a receiver stall loses no word
    if (pop)
    begin
      if (st_q.v1)
      begin
        st_d.head = st_q.tail;
        st_d.v1   = 1'b0;
      end
      else
        st_d.v0 = 1'b0;
    end
    if (push)
    begin
      if (!st_d.v0)
      begin
        st_d.head = word;
        st_d.v0   = 1'b1;
      end
      else
      begin
        st_d.tail = word;
        st_d.v1   = 1'b1;
      end
    end

    // SPI slave; sclk is oversampled so it must run well below clk/4
    st_d.sclk_s1 = spi_sclk_i;
    st_d.sclk_s2 = st_q.sclk_s1;
    st_d.sclk_s3 = st_q.sclk_s2;
    st_d.csb_s1  = spi_csb_i;
    st_d.csb_s2  = st_q.csb_s1;
    st_d.sdi_s1  = sdio_i;
    st_d.sdi_s2  = st_q.sdi_s1;
    // The read bit keeps moving up the shifter, so follow it by the bit count
    if (st_q.bit_cnt != 5'd0)
      rd_en = st_q.shift[st_q.bit_cnt - 5'd1];
    addr  = st_q.shift[14:0];
    if (st_q.csb_s2)
    begin
      st_d.bit_cnt = 5'd0;
      st_d.sdo_oe  = 1'b0;
      st_d.sdo     = 1'b0;
    end
    else if (st_q.sclk_s2 && !st_q.sclk_s3 && st_q.bit_cnt < 5'd24)
    begin
      st_d.shift   = {st_q.shift[aldm_pkg::SPI_TOTAL_W-2:0], st_q.sdi_s2};
      st_d.bit_cnt = st_q.bit_cnt + 5'd1;
      if (st_q.bit_cnt == 5'd15)
      begin
        addr = {st_q.shift[13:0], st_q.sdi_s2};
        if (addr == aldm_pkg::ADDR_DETECT_FLAGS_POWER)
          st_d.rdata = {st_q.pwr, 2'b00, st_q.fd_flag};
        else if (addr == aldm_pkg::ADDR_UPPER_THRESHOLD_LO)
          st_d.rdata = st_q.up_lo;
        else if (addr == aldm_pkg::ADDR_UPPER_THRESHOLD_HI)
          st_d.rdata = st_q.up_hi;
        else if (addr == aldm_pkg::ADDR_LOWER_THRESHOLD_LO)
          st_d.rdata = st_q.lo_lo;
        else if (addr == aldm_pkg::ADDR_LOWER_THRESHOLD_HI)
          st_d.rdata = st_q.lo_hi;
        else if (addr == aldm_pkg::ADDR_DWELL_TIME_LO)
          st_d.rdata = st_q.dw_lo;
        else if (addr == aldm_pkg::ADDR_DWELL_TIME_HI)
          st_d.rdata = st_q.dw_hi;
        else if (addr == aldm_pkg::ADDR_MONITOR_CONTROL)
          st_d.rdata = st_q.mon_ctl;
        else if (addr == aldm_pkg::ADDR_MONITOR_PERIOD_0)
          st_d.rdata = st_q.period[0];
        else if (addr == aldm_pkg::ADDR_MONITOR_PERIOD_1)
          st_d.rdata = st_q.period[1];
        else if (addr == aldm_pkg::ADDR_MONITOR_PERIOD_2)
          st_d.rdata = st_q.period[2];
        else if (addr == aldm_pkg::ADDR_PEAK_HOLD_LO)
          st_d.rdata = st_q.hold[7:0];
        else if (addr == aldm_pkg::ADDR_PEAK_HOLD_HI)
          st_d.rdata = {3'b000, st_q.hold[12:8]};
        else if (addr == aldm_pkg::ADDR_SERIAL_MON_EN_A)
          st_d.rdata = st_q.ser_a;
        else if (addr == aldm_pkg::ADDR_SERIAL_MON_EN_B)
          st_d.rdata = st_q.ser_b;
        else
          st_d.rdata = 8'h00;
      end
      if (st_q.bit_cnt == 5'd23 && !rd_en)
      begin
        wdat = {st_q.shift[6:0], st_q.sdi_s2};
        addr = st_q.shift[21:7];
        if (addr == aldm_pkg::ADDR_DETECT_FLAGS_POWER)
          st_d.pwr = wdat[aldm_pkg::POS_PWR_LSB +: 2];
        else if (addr == aldm_pkg::ADDR_UPPER_THRESHOLD_LO)
          st_d.up_lo = wdat;
        else if (addr == aldm_pkg::ADDR_UPPER_THRESHOLD_HI)
          st_d.up_hi = {3'b000, wdat[4:0]};
        else if (addr == aldm_pkg::ADDR_LOWER_THRESHOLD_LO)
          st_d.lo_lo = wdat;
        else if (addr == aldm_pkg::ADDR_LOWER_THRESHOLD_HI)
          st_d.lo_hi = {3'b000, wdat[4:0]};
        else if (addr == aldm_pkg::ADDR_DWELL_TIME_LO)
          st_d.dw_lo = wdat;
        else if (addr == aldm_pkg::ADDR_DWELL_TIME_HI)
          st_d.dw_hi = wdat;
        else if (addr == aldm_pkg::ADDR_MONITOR_CONTROL)
          st_d.mon_ctl = wdat;
        else if (addr == aldm_pkg::ADDR_MONITOR_PERIOD_0)
          st_d.period[0] = wdat;
        else if (addr == aldm_pkg::ADDR_MONITOR_PERIOD_1)
          st_d.period[1] = wdat;
        else if (addr == aldm_pkg::ADDR_MONITOR_PERIOD_2)
          st_d.period[2] = wdat;
        else if (addr == aldm_pkg::ADDR_SERIAL_MON_EN_A)
          st_d.ser_a = wdat;
        else if (addr == aldm_pkg::ADDR_SERIAL_MON_EN_B)
          st_d.ser_b = wdat;
      end
    end
    else if (!st_q.sclk_s2 && st_q.sclk_s3 && rd_en && st_q.bit_cnt >= 5'd16)
    begin
      // Read data leaves on falling edges, MSB first
      st_d.sdo_oe = (st_q.bit_cnt < 5'd24);
      st_d.sdo    = st_q.rdata[7];
      st_d.rdata  = {st_q.rdata[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      st_q        <= '0;
      st_q.up_lo  <= aldm_pkg::RST_UPPER_LO;
      st_q.up_hi  <= aldm_pkg::RST_UPPER_HI;
      st_q.dw_lo  <= aldm_pkg::RST_DWELL_LO;
      st_q.seed   <= 1'b1;
      st_q.sclk_s1 <= 1'b0;
      st_q.csb_s1 <= 1'b1;
      st_q.csb_s2 <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign fast_detect_out_a = st_q.fd_flag[0];
  assign fast_detect_out_b = st_q.fd_flag[1];
  assign fast_detect_out_c = st_q.fd_flag[2];
  assign fast_detect_out_d = st_q.fd_flag[3];
  assign power_mode_o      = st_q.pwr;
  assign sdio_o            = st_q.sdo;
  assign sdio_oe_o         = st_q.sdo_oe;
  assign out_data_o        = st_q.head;
  assign out_valid_o       = st_q.v0;
  assign samp_ready_o      = !st_q.v1;

endmodule // aldm_core

/* File: sim/aldm_core_monitor.sv */
// Port-level checker for the level detect and monitor core
`timescale 1ns/1ns
module aldm_core_monitor (
  input wire logic                           clk_i,
  input wire logic                           rst_b_i,
  input wire logic                           spi_csb_i,
  input wire logic                           sdio_oe_o,
  input wire aldm_pkg::aldm_samp_t           samp_i,
  input wire logic                           samp_valid_i,
  input wire logic                           samp_ready_o,
  input wire logic [aldm_pkg::WORD_W-1:0]    out_data_o,
  input wire logic                           out_valid_o,
  input wire logic                           out_ready_i,
  input wire logic                           fast_detect_out_a,
  input wire logic                           fast_detect_out_b,
  input wire logic [1:0]                     power_mode_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_push_empty;
    samp_valid_i && samp_ready_o && !out_valid_o;
  endsequence
  sequence s_head_held;
    out_valid_o && !out_ready_i;
  endsequence

  chk_reset_quiet: assert property ($rose(rst_b_i) |-> samp_ready_o && !out_valid_o
    && !fast_detect_out_a && power_mode_o == 2'h0) else $error("outputs not idle after reset");
  chk_push_shows: assert property (s_push_empty |=> out_valid_o)
    else $error("pushed word not visible");
  chk_push_top_bits: assert property (s_push_empty |=>
    out_data_o[15:3] == $past(samp_i.data[0][13:1])) else $error("sample bits not kept");
  chk_head_stable: assert property (s_head_held |=> out_valid_o && $stable(out_data_o))
    else $error("head word changed while stalled");
  chk_full_refuse: assert property (!samp_ready_o |-> out_valid_o)
    else $error("refusing with empty buffer");
  chk_flag_cause_a: assert property ($rose(fast_detect_out_a) |->
    $past(samp_i.data[0]) != 14'h0000) else $error("flag A rose on zero sample");
  chk_flag_cause_b: assert property ($rose(fast_detect_out_b) |->
    $past(samp_i.data[1]) != 14'h0000) else $error("flag B rose on zero sample");
  chk_flag_min_width: assert property ($rose(fast_detect_out_a) |=> fast_detect_out_a)
    else $error("flag cleared inside dwell");
  chk_sdio_quiet: assert property (spi_csb_i [*6] |-> !sdio_oe_o)
    else $error("sdio driven while deselected");
  chk_sdio_select: assert property ($rose(sdio_oe_o) |-> !$past(spi_csb_i, 3))
    else $error("sdio driven without select");
endmodule // aldm_core_monitor

bind aldm_core aldm_core_monitor aldm_core_monitor_i (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .spi_csb_i(spi_csb_i), .sdio_oe_o(sdio_oe_o),
  .samp_i(samp_i), .samp_valid_i(samp_valid_i), .samp_ready_o(samp_ready_o),
  .out_data_o(out_data_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
  .fast_detect_out_a(fast_detect_out_a), .fast_detect_out_b(fast_detect_out_b),
  .power_mode_o(power_mode_o));

/* File: sim/aldm_jesd_rx.sv */
// Receiver model: takes words and rebuilds monitor frames from the top control bit
`timescale 1ns/1ns
module aldm_jesd_rx (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [15:0] data_i,
  input  wire logic        valid_i,
  input  wire logic        stall_i,
  output logic             ready_o,
  output logic [12:0]      peak_o,
  output logic [7:0]       frames_o
);
  logic [24:0] sr_q;
  logic [4:0]  cnt_q;
  logic [24:0] f;
  // Stalls come from the bench so slow answers can be exercised
  assign ready_o = !stall_i;
  assign f = {sr_q[23:0], data_i[2]};
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
    begin
      sr_q <= '0;
      cnt_q <= 5'h00;
      peak_o <= 13'h0000;
      frames_o <= 8'h00;
    end
    else if (valid_i && ready_o)
    begin
      // Idle bits are zero, so the first one seen opens a frame
      if (cnt_q != 5'h00 || data_i[2])
      begin
        sr_q <= f;
        cnt_q <= (cnt_q == 5'h18) ? 5'h00 : cnt_q + 5'h01;
      end
      // Each subframe must open with its start bit
      if (cnt_q == 5'h18 && f[24] && f[19] && f[14] && f[9] && f[4]
          && f[23:20] == 4'h0 && f[18:16] == 3'h0)
      begin
        peak_o <= {f[15], f[13:10], f[8:5], f[3:0]};
        frames_o <= frames_o + 8'h01;
      end
    end
  end
endmodule // aldm_jesd_rx

/* File: sim/aldm_core_tb_top.sv */
// Testbench: register port, fast detect, peak monitor and embedded frame checks
`timescale 1ns/1ns
module aldm_core_tb_top;
  logic                 clk_i = 1'b0;
  logic                 rst_b_i = 1'b0;
  logic                 spi_sclk_i = 1'b0;
  logic                 spi_csb_i = 1'b1;
  logic                 sdio_i = 1'b0;
  logic                 samp_valid_i = 1'b0;
  logic                 dec_en_i = 1'b0;
  logic                 stall = 1'b0;
  aldm_pkg::aldm_samp_t samp_i = '0;
  logic                 sdio_o, sdio_oe_o, samp_ready_o, out_valid_o, out_ready_i;
  logic                 fd_a, fd_b, fd_c, fd_d;
  logic [1:0]           power_mode_o;
  logic [15:0]          out_data_o;
  logic [12:0]          rx_peak;
  logic [7:0]           rx_frames;
  logic [3:0]           fl;
  int                   errors = 0;
  int                   n_tests = 0;
  logic [22:0] rt0 [8] = '{{15'h0247, 8'hFF}, {15'h0248, 8'h1F}, {15'h024B, 8'h01},
    {15'h024C, 8'h00}, {15'h0249, 8'h00}, {15'h0270, 8'h00}, {15'h0040, 8'h00},
    {15'h0300, 8'h00}};
  logic [22:0] rt1 [13] = '{{15'h024B, 8'hFF}, {15'h024C, 8'hFF}, {15'h0273, 8'hA5},
    {15'h0249, 8'h34}, {15'h024A, 8'h12}, {15'h0247, 8'h00}, {15'h0248, 8'h01},
    {15'h0249, 8'h80}, {15'h024A, 8'h00}, {15'h024B, 8'h02}, {15'h024C, 8'h00},
    {15'h0273, 8'h00}, {15'h0271, 8'h04}};
  logic [13:0] pk [12] = '{14'h0005, 14'h3D44, 14'h012C, 14'h0014, 14'h000A, 14'h0032,
    14'h001E, 14'h0028, 14'h2000, 14'h0001, 14'h0002, 14'h0003};
  logic [12:0] pe [3] = '{13'h02BC, 13'h0032, 13'h1FFF};

  assign fl = {fd_d, fd_c, fd_b, fd_a};
  always #5 clk_i = ~clk_i;

  aldm_core aldm_core_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .spi_sclk_i(spi_sclk_i), .spi_csb_i(spi_csb_i),
    .sdio_i(sdio_i), .sdio_o(sdio_o), .sdio_oe_o(sdio_oe_o), .samp_i(samp_i),
    .samp_valid_i(samp_valid_i), .samp_ready_o(samp_ready_o), .dec_en_i(dec_en_i),
    .out_data_o(out_data_o), .out_valid_o(out_valid_o), .out_ready_i(out_ready_i),
    .fast_detect_out_a(fd_a), .fast_detect_out_b(fd_b), .fast_detect_out_c(fd_c),
    .fast_detect_out_d(fd_d), .power_mode_o(power_mode_o));

  aldm_jesd_rx aldm_jesd_rx_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .data_i(out_data_o), .valid_i(out_valid_o),
    .stall_i(stall), .ready_o(out_ready_i), .peak_o(rx_peak), .frames_o(rx_frames));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Each sclk phase spans four clocks since the pins pass a two-flop sync
  task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                     output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, wd};
    q = 8'h00;
    spi_csb_i = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      sdio_i = f[i];
      cyc(4);
      spi_sclk_i = 1'b1;
      if (i < 8)
        q[i] = sdio_o;
      cyc(4);
      spi_sclk_i = 1'b0;
    end
    cyc(4);
    spi_csb_i = 1'b1;
    cyc(6);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] v;
    spi(1'b0, a, d, v);
  endtask

  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    logic [7:0] v;
    spi(1'b1, a, 8'h00, v);
    chk(16'(v), 16'(e));
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk_i);
    errors++;
    report_and_stop();
  end

  initial
  begin
    cyc(6);
    rst_b_i = 1'b1;
    cyc(3);
    foreach (rt0[i]) rd(rt0[i][22:8], rt0[i][7:0]);
    foreach (rt1[i])
    begin
      wr(rt1[i][22:8], rt1[i][7:0]);
      rd(rt1[i][22:8], rt1[i][7:0]);
    end
    samp_i = {14'h2000, 14'h0100, 14'h3EFF, 14'h0101};
    cyc(1);
    chk(16'(fl), 16'h000B);
    samp_i = {4{14'h00C8}};
    rd(aldm_pkg::ADDR_DETECT_FLAGS_POWER, 8'h0B);
    samp_i = '0;
    cyc(2);
    samp_i = {4{14'h0080}};
    cyc(1);
    samp_i = '0;
    cyc(2);
    chk(16'(fl), 16'h000B);
    cyc(1);
    chk(16'(fl), 16'h0000);
    wr(aldm_pkg::ADDR_DETECT_FLAGS_POWER, 8'hC0);
    chk(16'(power_mode_o), 16'h0003);
    rd(aldm_pkg::ADDR_DETECT_FLAGS_POWER, 8'hC0);
    wr(aldm_pkg::ADDR_MONITOR_CONTROL, 8'h02);
    cyc(4);
    for (int i = 0; i < 12; i++)
    begin
      samp_i.data[0] = pk[i];
      dec_en_i = 1'b1;
      cyc(1);
      dec_en_i = 1'b0;
      cyc(1);
      if (i % 4 == 3)
      begin
        rd(aldm_pkg::ADDR_PEAK_HOLD_LO, pe[i / 4][7:0]);
        rd(aldm_pkg::ADDR_PEAK_HOLD_HI, {3'h0, pe[i / 4][12:8]});
      end
    end
    wr(aldm_pkg::ADDR_SERIAL_MON_EN_A, 8'h03);
    wr(aldm_pkg::ADDR_SERIAL_MON_EN_B, 8'h12);
    samp_i = {4{14'h1555}};
    samp_valid_i = 1'b1;
    stall = 1'b1;
    cyc(4);
    chk(16'(samp_ready_o), 16'h0000);
    chk(16'(out_data_o[1:0]), 16'h0001);
    // Stalls thin accepted samples below one frame per period, so a newer peak overwrites the pending one
    for (int i = 0; i < 300; i++)
    begin
      dec_en_i = (i % 8 == 0);
      stall = (i % 3 == 0);
      cyc(1);
    end
    dec_en_i = 1'b0;
    stall = 1'b0;
    samp_valid_i = 1'b0;
    cyc(4);
    chk(16'(rx_frames != 8'h00), 16'h0001);
    chk(16'(rx_peak), 16'h1555);
    // No control bits: low lanes carry sample bits again
    wr(aldm_pkg::ADDR_SERIAL_MON_EN_B, 8'h02);
    samp_valid_i = 1'b1;
    cyc(1);
    samp_valid_i = 1'b0;
    chk(out_data_o, 16'h5555);
    chk(16'(out_valid_o), 16'h0001);
    cyc(2);
    chk(16'(out_valid_o), 16'h0000);
    chk(16'(samp_ready_o), 16'h0001);
    report_and_stop();
  end
endmodule // aldm_core_tb_top
